// ===== logic/irc_regs.svh
// Constants of the regulator configuration register block.
// Assumes a 200 MHz core clock; included by bare name by the timer and top design files.
`ifndef IRC_REGS_SVH
`define IRC_REGS_SVH

// Frame layout of the 16-bit command word
`define IRC_CMD_HI        15
`define IRC_CMD_LO        14
`define IRC_ADDR_HI       13
`define IRC_ADDR_LO       9
`define IRC_PAR_BIT       8
`define IRC_FRAME_BITS    5'h10
`define IRC_FIRST_BITS    5'h08

// Command codes and the address of this register
`define IRC_CMD_WRITE     2'h1
`define IRC_CMD_READ      2'h0
`define IRC_ADDR          5'h05

// Register reset value and field positions
`define IRC_RESET_VAL     8'h80
`define IRC_SYNC_BIT      7
`define IRC_UVL_HI        6
`define IRC_UVL_LO        5
`define IRC_RSTD_HI       4
`define IRC_RSTD_LO       3
`define IRC_AUX_BIT       2
`define IRC_ON_HI         1
`define IRC_ON_LO         0

// Undervoltage response codes
`define IRC_UVL_INT_090   2'h1
`define IRC_UVL_RST_070   2'h2

// Timing: clock rate and the 1 us tick
`define IRC_CLK_MHZ       200
`define IRC_TICK_US       1
`define IRC_TICK_CYCLES   (`IRC_CLK_MHZ * `IRC_TICK_US)

// Reset pulse lengths in ms, as selected by the pulse length field
`define IRC_RSTD0_MS      1
`define IRC_RSTD1_MS      5
`define IRC_RSTD2_MS      10
`define IRC_RSTD3_MS      20
`define IRC_US_PER_MS     1000

// Wake output active times in us during cyclic sensing
`define IRC_ON0_US        200
`define IRC_ON1_US        400
`define IRC_ON2_US        800
`define IRC_ON3_US        1600

`endif

// ===== logic/irc_pkg.sv
// Types shared by the regulator configuration register block.
// Constants live in irc_regs.svh; this package holds types only.
package irc_pkg;

	// Serial frame receiver state
	typedef enum logic {
		IRC_IDLE,
		IRC_SHIFT
	} irc_spi_state_t;

	// One register byte
	typedef logic [7:0] irc_byte_t;

endpackage

// ===== logic/irc_timer.sv
// Down counter of 1 us ticks, used for the reset pulse and the wake on-time.
// Assumes tick is a one-cycle enable from the divider in the same clock domain.
`timescale 1ns/10ps
`include "irc_regs.svh"

module irc_timer #(
	parameter int W = 15                    // Counter width
) (
	input  wire logic         clk,          // Core clock
	input  wire logic         rst,          // Asynchronous reset, active high
	input  wire logic         tick,         // 1 us enable pulse
	input  wire logic         load,         // Load request, wins over counting
	input  wire logic [W-1:0] load_val,     // Ticks to run
	output logic              busy          // High while the count is not zero
);

	logic [W-1:0] cnt_r;                    // Remaining ticks
	logic [W-1:0] cnt_nxt;                  // Next count

	// Load wins so a held load keeps the timer primed
	assign cnt_nxt = load ? load_val :
	                 (tick && cnt_r != '0) ? cnt_r - W'(1) : cnt_r;
	assign busy    = (cnt_r != '0);

	// Count register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule

// ===== logic/irc_top.sv
// Regulator configuration register with its serial command port and the
// reset pulse, undervoltage response and cyclic wake timing it controls.
// Assumes serial pins and comparators arrive asynchronously; mode and
// cyclic trigger come from logic on clk.
// Behaviour
// - Select register on first byte address 0_0101
// - Writes accepted only in initialization mode
// - Bit 7 gates second wake input sampling
// - Bits 6:5 choose undervoltage reset/interrupt levels
// - Bits 4:3 set reset hold 1-20 ms
// - Bit 2 selects auxiliary output 3.3/5 V
// - Bits 1:0 set wake output time 200-1600 us
`timescale 1ns/10ps
`include "irc_regs.svh"

module irc_top #(
	parameter int TICK_CYCLES = `IRC_TICK_CYCLES,               // Clocks per 1 us tick
	parameter int RSTD0_US    = `IRC_RSTD0_MS * `IRC_US_PER_MS, // Reset hold, code 00
	parameter int RSTD1_US    = `IRC_RSTD1_MS * `IRC_US_PER_MS, // Reset hold, code 01
	parameter int RSTD2_US    = `IRC_RSTD2_MS * `IRC_US_PER_MS, // Reset hold, code 10
	parameter int RSTD3_US    = `IRC_RSTD3_MS * `IRC_US_PER_MS, // Reset hold, code 11
	parameter int ON0_US      = `IRC_ON0_US,                    // Wake on-time, code 00
	parameter int ON1_US      = `IRC_ON1_US,                    // Wake on-time, code 01
	parameter int ON2_US      = `IRC_ON2_US,                    // Wake on-time, code 10
	parameter int ON3_US      = `IRC_ON3_US                     // Wake on-time, code 11
) (
	input  wire logic       clk,                        // 200 MHz core clock
	input  wire logic       rst,                        // Power-on reset, async, high
	input  wire logic       spi_sclk,                   // Serial clock pin
	input  wire logic       spi_cs_n,                   // Chip select pin, low active
	input  wire logic       spi_mosi,                   // Serial data in pin
	output logic            spi_miso_out,               // Serial data out level
	output logic            spi_miso_oe_n,              // Low while driving MISO
	input  wire logic       init_mode,                  // Device in initialization mode
	input  wire logic       parity_en,                  // Frame parity checking on
	input  wire logic       uv_below_090,               // Supply below 0.9 comparator
	input  wire logic       uv_below_070,               // Supply below 0.7 comparator
	input  wire logic       cyclic_en,                  // Cyclic sensing active
	input  wire logic       cyclic_trigger,             // Start of a sense period
	output logic [7:0]      config_value,               // Register contents
	output logic [1:0]      undervoltage_level_select,  // Undervoltage response field
	output logic [1:0]      reset_pulse_length_select,  // Reset hold field
	output logic            aux_voltage_select,         // 1 = 5.0 V, 0 = 3.3 V
	output logic            reset_out_n,                // Reset pin level, low active
	output logic            uv_irq,                     // Early undervoltage interrupt
	output logic            wake0_active,               // First wake output drive
	output logic            wake1_sample_en             // Second wake input sample gate
);

	// Input synchronisers, first stage read only by the second
	logic [4:0] sync1_r;                    // First stage
	logic [4:0] sync2_r;                    // Second stage
	logic       sclk_d_r;                   // Delayed clean serial clock
	logic       cs_d_r;                     // Delayed clean chip select

	// Serial receiver
	irc_pkg::irc_spi_state_t state_r;       // Frame state
	logic [15:0]  rx_r;                     // Received bits, MSB first
	logic [4:0]   bits_r;                   // Bits received, saturating
	logic [7:0]   tx_r;                     // Outgoing byte
	irc_pkg::irc_byte_t cfg_r;              // The configuration register

	// Timing
	logic [7:0]   div_r;                    // Tick divider
	logic         tick;                     // 1 us enable pulse
	logic         rst_busy;                 // Reset hold running
	logic         on_busy;                  // Wake on-time running
	logic         reset_out_n_r;            // Registered reset pin
	logic         uv_irq_r;                 // Registered interrupt
	logic         wake0_r;                  // Registered wake drive

	// Clean views of the pins
	wire sclk_s = sync2_r[0];
	wire cs_n_s = sync2_r[1];
	wire mosi_s = sync2_r[2];
	wire uv90_s = sync2_r[3];
	wire uv70_s = sync2_r[4];

	// Edge strobes on the synchronised serial pins
	wire sclk_rise = sclk_s & ~sclk_d_r;
	wire sclk_fall = ~sclk_s & sclk_d_r;
	wire cs_fall   = ~cs_n_s & cs_d_r;
	wire cs_rise   = cs_n_s & ~cs_d_r;

	// Decode of the received frame
	wire [1:0] cmd_code  = rx_r[`IRC_CMD_HI:`IRC_CMD_LO];
	wire [4:0] addr_code = rx_r[`IRC_ADDR_HI:`IRC_ADDR_LO];
	wire [4:0] addr_first = rx_r[5:1];       // Address while only byte one is in
	wire [1:0] cmd_first  = rx_r[7:6];       // Command while only byte one is in
	wire       addr_hit  = (addr_code == `IRC_ADDR);
	wire       read_hit  = (addr_first == `IRC_ADDR) &&
	                       (cmd_first == `IRC_CMD_READ);
	// Odd parity over the whole word; the parity bit makes the count odd
	wire       par_ok    = ~parity_en | (^rx_r);
	wire       full_frame = (bits_r == `IRC_FRAME_BITS);
	// Only complete, addressed write frames in initialization mode commit
	wire       wr_commit = cs_rise && (state_r == irc_pkg::IRC_SHIFT) && full_frame &&
	                       addr_hit && (cmd_code == `IRC_CMD_WRITE) && par_ok &&
	                       init_mode;

	// Field views of the register
	wire       sync_sel = cfg_r[`IRC_SYNC_BIT];
	wire [1:0] uvl_sel  = cfg_r[`IRC_UVL_HI:`IRC_UVL_LO];
	wire [1:0] rstd_sel = cfg_r[`IRC_RSTD_HI:`IRC_RSTD_LO];
	wire [1:0] on_sel   = cfg_r[`IRC_ON_HI:`IRC_ON_LO];

	// Undervoltage response: 00 and 11 reset at 0.9, 10 at 0.7, 01 warns at 0.9 and resets at 0.7
	wire uv_rst_low = (uvl_sel == `IRC_UVL_RST_070) ||
	                  (uvl_sel == `IRC_UVL_INT_090);
	wire uv_reset   = uv_rst_low ? uv70_s : uv90_s;
	wire uv_warn    = (uvl_sel == `IRC_UVL_INT_090) & uv90_s;

	// Reset hold length in ticks
	wire [14:0] rstd_ticks = (rstd_sel == 2'h0) ? 15'(RSTD0_US) :
	                         (rstd_sel == 2'h1) ? 15'(RSTD1_US) :
	                         (rstd_sel == 2'h2) ? 15'(RSTD2_US) :
	                                              15'(RSTD3_US);

	// Wake on-time in ticks
	wire [14:0] on_ticks = (on_sel == 2'h0) ? 15'(ON0_US) :
	                       (on_sel == 2'h1) ? 15'(ON1_US) :
	                       (on_sel == 2'h2) ? 15'(ON2_US) :
	                                          15'(ON3_US);

	// A new period only starts once the last on-time has ended
	wire on_start = cyclic_en & cyclic_trigger & ~on_busy;

	// Divider tick strobe
	assign tick = (div_r == 8'(TICK_CYCLES - 1));

	// Pin synchronisers; the delayed copies read only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_r  <= 5'h02;
			sync2_r  <= 5'h02;
			sclk_d_r <= 1'b0;
			cs_d_r   <= 1'b1;
		end else begin
			sync1_r  <= {uv_below_070, uv_below_090, spi_mosi, spi_cs_n, spi_sclk};
			sync2_r  <= sync1_r;
			sclk_d_r <= sclk_s;
			cs_d_r   <= cs_n_s;
		end
	end

	// Frame state: shifting while select is low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= irc_pkg::IRC_IDLE;
		end else begin
			case (state_r)
				irc_pkg::IRC_IDLE: begin
					if (cs_fall) begin
						state_r <= irc_pkg::IRC_SHIFT;
					end
				end
				irc_pkg::IRC_SHIFT: begin
					if (cs_rise) begin
						state_r <= irc_pkg::IRC_IDLE;
					end
				end
				default: begin
					state_r <= irc_pkg::IRC_IDLE;
				end
			endcase
		end
	end

	// Receive shifter, sampled on the rising serial edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_r   <= 16'h0000;
			bits_r <= 5'h00;
		end else if (cs_fall) begin
			rx_r   <= 16'h0000;
			bits_r <= 5'h00;
		end else if (state_r == irc_pkg::IRC_SHIFT && sclk_rise) begin
			rx_r   <= {rx_r[14:0], mosi_s};
			// Saturate so long frames never wrap back to sixteen
			bits_r <= (bits_r == 5'h1f) ? bits_r : bits_r + 5'h01;
		end
	end

	// Transmit byte: zeros first, register contents after a read header
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_r <= 8'h00;
		end else if (cs_fall) begin
			tx_r <= 8'h00;
		end else if (state_r == irc_pkg::IRC_SHIFT && sclk_fall) begin
			if (bits_r == `IRC_FIRST_BITS) begin
				tx_r <= read_hit ? cfg_r : 8'h00;
			end else begin
				tx_r <= {tx_r[6:0], 1'b0};
			end
		end
	end

	// The register; any refused write leaves it untouched
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_r <= `IRC_RESET_VAL;
		end else if (wr_commit) begin
			cfg_r <= rx_r[7:0];
		end
	end

	// 1 us tick divider
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_r <= 8'h00;
		end else begin
			div_r <= tick ? 8'h00 : div_r + 8'h01;
		end
	end

	// Reset hold: primed while low, runs once the supply recovers
	irc_timer #(
		.W        (15)
	) u_rst_timer (
		.clk      (clk),
		.rst      (rst),
		.tick     (tick),
		.load     (uv_reset),
		.load_val (rstd_ticks),
		.busy     (rst_busy)
	);

	// Wake output on-time
	irc_timer #(
		.W        (15)
	) u_on_timer (
		.clk      (clk),
		.rst      (rst),
		.tick     (tick),
		.load     (on_start),
		.load_val (on_ticks),
		.busy     (on_busy)
	);

	// Registered pin levels; the hold covers the undervoltage and its tail
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reset_out_n_r <= 1'b0;
			uv_irq_r      <= 1'b0;
			wake0_r       <= 1'b0;
		end else begin
			reset_out_n_r <= ~(uv_reset | rst_busy);
			uv_irq_r      <= uv_warn;
			wake0_r       <= cyclic_en & on_busy;
		end
	end

	// Outputs
	assign spi_miso_out              = tx_r[7];
	assign spi_miso_oe_n             = (state_r != irc_pkg::IRC_SHIFT);
	assign config_value              = cfg_r;
	assign undervoltage_level_select = uvl_sel;
	assign reset_pulse_length_select = rstd_sel;
	assign aux_voltage_select        = cfg_r[`IRC_AUX_BIT];
	assign reset_out_n               = reset_out_n_r;
	assign uv_irq                    = uv_irq_r;
	assign wake0_active              = wake0_r;
	// Outside cyclic sensing the second input is always sampled
	assign wake1_sample_en           = ~cyclic_en | ~sync_sel | wake0_r;

endmodule

// ===== tb/irc_host.sv
// Host model: serial master sending 16-bit frames, MSB first.
// Assumes clk is the device clock; sclk idles low between frames.
`timescale 1ns/10ps
module irc_host (
	input  wire logic clk,      // Device clock
	output logic      spi_sclk, // Serial clock
	output logic      spi_cs_n, // Select, low active
	output logic      spi_mosi, // Data to device
	input  wire logic spi_miso  // Data from device
);
	// Idle levels at time zero
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// One frame; phases of 6 clocks keep sclk well above the sync minimum
	task automatic frame(input logic [15:0] w, output logic [7:0] rd);
		rd = 8'h00;
		@(negedge clk);
		spi_cs_n = 1'b0;
		repeat (4) @(negedge clk);
		for (int i = 15; i >= 0; i--) begin
			spi_mosi = w[i];
			repeat (6) @(negedge clk);
			if (i < 8)
				rd = {rd[6:0], spi_miso};
			spi_sclk = 1'b1;
			repeat (6) @(negedge clk);
			spi_sclk = 1'b0;
		end
		repeat (4) @(negedge clk);
		spi_cs_n = 1'b1;
		// Released line must not keep showing the last bit
		spi_mosi = ~spi_mosi;
		repeat (8) @(negedge clk);
	endtask
endmodule

// ===== tb/irc_top_monitor.sv
// Checker of the regulator configuration register ports.
// Assumes it is bound into irc_top and sees only its ports.
`timescale 1ns/10ps
module irc_top_monitor #(
	parameter int TICK_CYCLES = 200, // Clocks per tick
	parameter int ON3_US      = 1600 // Longest wake time
) (
	input wire logic       clk,                       // Core clock
	input wire logic       rst,                       // Async reset
	input wire logic       spi_cs_n,                  // Select pin
	input wire logic       spi_miso_oe_n,             // Out enable, low
	input wire logic       init_mode,                 // Write window
	input wire logic       uv_below_090,              // 0.9 comparator
	input wire logic       cyclic_en,                 // Cyclic sensing
	input wire logic       cyclic_trigger,            // Period start
	input wire logic [7:0] config_value,              // Register
	input wire logic [1:0] undervoltage_level_select, // Bits 6:5
	input wire logic [1:0] reset_pulse_length_select, // Bits 4:3
	input wire logic       aux_voltage_select,        // Bit 2
	input wire logic       reset_out_n,               // Reset pin
	input wire logic       uv_irq,                    // Early warning
	input wire logic       wake0_active,              // Wake output
	input wire logic       wake1_sample_en            // Sample gate
);
	// Longest legal wake span, with two ticks of slack and sync delay
	localparam int WMAX = (ON3_US + 2) * TICK_CYCLES + 4;
	logic [19:0] wake_len_r; // Cycles the wake output has stood

	// Length counter, cleared whenever the wake output drops
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			wake_len_r <= 20'h00000;
		else if (wake0_active)
			wake_len_r <= wake_len_r + 20'h00001;
		else
			wake_len_r <= 20'h00000;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Trigger after the timer has surely gone idle
	sequence idle_trig_s;
		(!wake0_active)[*3] ##0 (cyclic_en && cyclic_trigger);
	endsequence

	reset_val_a: assert property ($fell(rst) |-> config_value == 8'h80)
		else $error("Config not at reset value after release");
	write_lock_a: assert property ((!init_mode)[*2] |=> $stable(config_value))
		else $error("Config changed outside init mode");
	field_map_a: assert property ({undervoltage_level_select, reset_pulse_length_select,
		aux_voltage_select} == config_value[6:2])
		else $error("Field outputs differ from config");
	wake_gate_a: assert property (wake1_sample_en ==
		(!cyclic_en || !config_value[7] || wake0_active))
		else $error("Second wake sample gate wrong");
	uv_reset_a: assert property ((uv_below_090 && (undervoltage_level_select[1] ==
		undervoltage_level_select[0]))[*4] |-> ##[0:4] !reset_out_n)
		else $error("Reset missing at 0.9 threshold");
	irq_code_a: assert property (uv_irq && $stable(undervoltage_level_select)
		|-> undervoltage_level_select == 2'h1)
		else $error("Interrupt with wrong level code");
	wake_start_a: assert property (idle_trig_s ##1 cyclic_en[*3] |-> wake0_active)
		else $error("Wake output did not start");
	wake_len_a: assert property (wake_len_r <= 20'(WMAX))
		else $error("Wake output too long");
	wake_off_a: assert property (!cyclic_en |=> !wake0_active)
		else $error("Wake output on without cyclic sensing");
	cs_idle_a: assert property (spi_cs_n[*5] |-> spi_miso_oe_n)
		else $error("Serial output driven while deselected");
endmodule

bind irc_top irc_top_monitor #(.TICK_CYCLES(TICK_CYCLES), .ON3_US(ON3_US)) i_mon (
	.clk(clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_miso_oe_n(spi_miso_oe_n),
	.init_mode(init_mode), .uv_below_090(uv_below_090), .cyclic_en(cyclic_en),
	.cyclic_trigger(cyclic_trigger), .config_value(config_value),
	.undervoltage_level_select(undervoltage_level_select),
	.reset_pulse_length_select(reset_pulse_length_select),
	.aux_voltage_select(aux_voltage_select), .reset_out_n(reset_out_n),
	.uv_irq(uv_irq), .wake0_active(wake0_active), .wake1_sample_en(wake1_sample_en));

// ===== tb/test_irc_top.sv
// Testbench of the regulator configuration register block.
// Assumes the host model on the serial pins and shortened timing.
`timescale 1ns/10ps
module test_irc_top;
	localparam int TK = 4;                 // Clocks per tick
	localparam int RS [4] = '{3, 5, 7, 9}; // Reset hold ticks by code
	localparam int ON [4] = '{2, 4, 6, 8}; // Wake ticks by code
	logic       clk = 1'b0;                // Core clock
	logic       rst = 1'b1;                // Power-on reset
	logic       sclk, cs_n, mosi, miso;    // Serial pins
	logic       oe_n;                      // Serial out enable
	logic       init_m = 1'b1;             // Init mode
	logic       par_en = 1'b1;             // Parity checked
	logic       uv9 = 1'b0;                // Below 0.9
	logic       uv7 = 1'b0;                // Below 0.7
	logic       cyc = 1'b0;                // Cyclic sensing
	logic       trig = 1'b0;               // Period start
	logic [7:0] cfg, rd, model;            // Seen, read, expected
	logic [1:0] uvl, rsl;                  // Field outputs
	logic       aux, rst_o_n, irq, wk0, wk1; // Other outputs
	int         fail_count = 0;            // Mismatches
	int         check_count = 0;           // Comparisons
	int         n;                         // Measured span

	always #2.5 clk = ~clk;

	// Undriven serial output shows the inverse, so a late drive is caught
	wire        miso_pin = oe_n ? ~miso : miso; // Line seen by the host

	irc_host i_host (.clk(clk), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
		.spi_miso(miso_pin));
	irc_top #(.TICK_CYCLES(TK), .RSTD0_US(RS[0]), .RSTD1_US(RS[1]), .RSTD2_US(RS[2]),
		.RSTD3_US(RS[3]), .ON0_US(ON[0]), .ON1_US(ON[1]), .ON2_US(ON[2]),
		.ON3_US(ON[3])) i_dut (
		.clk(clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
		.spi_miso_out(miso), .spi_miso_oe_n(oe_n), .init_mode(init_m),
		.parity_en(par_en), .uv_below_090(uv9), .uv_below_070(uv7),
		.cyclic_en(cyc), .cyclic_trigger(trig), .config_value(cfg),
		.undervoltage_level_select(uvl), .reset_pulse_length_select(rsl),
		.aux_voltage_select(aux), .reset_out_n(rst_o_n), .uv_irq(irq),
		.wake0_active(wk0), .wake1_sample_en(wk1));

	// Command word with odd parity, broken when g is low
	function automatic logic [15:0] mkw(logic [1:0] c, logic [4:0] a, logic [7:0] d, logic g);
		logic [15:0] w;
		w = {c, a, 1'b0, d};
		w[8] = ~(^w) ^ ~g;
		return w;
	endfunction

	// Reset expected: 0.7 always resets, 0.9 only for codes 00 and 11
	function automatic logic uvr(int c, logic b70);
		return b70 || (c == 0) || (c == 3);
	endfunction

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Timing is typical, so a window of slack is allowed
	task automatic near(input string nm, input int e, input int g, input int tol);
		check_count++;
		if (g < e - tol || g > e + tol) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic g);
		i_host.frame(mkw(2'h1, a, d, g), rd);
	endtask

	task automatic test_done();
		$display("Checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'hda77));
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (5) @(negedge clk);
		model = 8'h80;
		chk("config", model, cfg);
		i_host.frame(mkw(2'h0, 5'h05, 8'h00, 1'b1), rd);
		chk("readback", model, rd);
		// Random writes; one to a neighbour address, one with bad parity
		for (int i = 0; i < 8; i++) begin
			logic [7:0] d;
			d = 8'($urandom);
			wr((i == 2) ? 5'h04 : 5'h05, d, i != 3);
			if (i != 2 && i != 3)
				model = d;
			chk("config", model, cfg);
			chk("fields", {3'h0, model[6:2]}, {3'h0, uvl, rsl, aux});
			i_host.frame(mkw(2'h0, 5'h05, 8'h00, 1'b1), rd);
			chk("readback", model, rd);
		end
		// Write outside init mode is dropped
		init_m = 1'b0;
		wr(5'h05, ~model, 1'b1);
		init_m = 1'b1;
		chk("locked", model, cfg);
		// Parity disabled: a frame with a wrong parity bit still commits
		par_en = 1'b0;
		model = 8'($urandom);
		wr(5'h05, model, 1'b0);
		par_en = 1'b1;
		chk("no_parity", model, cfg);
		// Each undervoltage code, then hold length after recovery
		for (int c = 0; c < 4; c++) begin
			wr(5'h05, {1'b0, 2'(c), 2'(c), 3'h0}, 1'b1);
			uv9 = 1'b1;
			repeat (20) @(negedge clk);
			chk("reset", {7'h0, ~uvr(c, 1'b0)}, {7'h0, rst_o_n});
			chk("irq", {7'h0, c == 1}, {7'h0, irq});
			uv7 = 1'b1;
			repeat (20) @(negedge clk);
			chk("reset", {7'h0, ~uvr(c, 1'b1)}, {7'h0, rst_o_n});
			uv9 = 1'b0;
			uv7 = 1'b0;
			n = 0;
			while (rst_o_n !== 1'b1 && n < 400) begin
				@(negedge clk);
				n++;
			end
			near("hold", RS[c] * TK, n, TK + 6);
		end
		// Wake on-time per code, gate with bit 7 both ways
		for (int c = 0; c < 4; c++) begin
			wr(5'h05, {c[0], 5'h00, 2'(c)}, 1'b1);
			cyc = 1'b1;
			repeat (3) @(negedge clk);
			chk("gate", {7'h0, ~c[0]}, {7'h0, wk1});
			trig = 1'b1;
			@(negedge clk);
			trig = 1'b0;
			repeat (3) @(negedge clk);
			chk("wake", 8'h01, {7'h0, wk0});
			chk("gate", 8'h01, {7'h0, wk1});
			n = 3;
			while (wk0 !== 1'b0 && n < 400) begin
				@(negedge clk);
				n++;
			end
			near("on_time", ON[c] * TK, n, TK + 4);
			cyc = 1'b0;
		end
		// Second power-on reset in mid-run restores the default
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		repeat (5) @(negedge clk);
		model = 8'h80;
		chk("config", model, cfg);
		chk("reset_pin", 8'h01, {7'h0, rst_o_n});
		i_host.frame(mkw(2'h0, 5'h05, 8'h00, 1'b1), rd);
		chk("readback", model, rd);
		test_done();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		test_done();
	end
endmodule
